// [rtl/mem_space_decoder.sv]
// Memory space size decoder: size registers, chip selects, flash blocks
// Assumes CPU bus on CLOCK_IN; size registers written by strobe ports
//
// Behaviour
// RQ1 - One 64 KB space with 16-bit addresses for all accesses
// RQ2 - Reset loads memory size CFH and expansion size 0CH
// RQ3 - Software writes memory size 04H, C6H, C8H, CCH or CFH per ROM
// RQ4 - Software writes expansion size 0AH with 1 KB RAM, else leaves 0CH
// RQ5 - Option bytes 0080H-0084H, security ID 0085H-008EH
// RQ6 - With boot swap, programmer duplicates both at 1080H-108EH
// RQ7 - Block writes to boot cluster 0 when security prohibits
// RQ8 - Flash split into equal 1 KB blocks
// RQ9 - Block number is address bits 15 to 10
// RQ10 - Valid block limit follows ROM size: 0FH to 3BH
// RQ11 - FF00H-FFFFH selects peripheral registers
// RQ12 - Chip selects follow programmed sizes, updated on each write
`timescale 1ns/1ps
module mem_space_decoder
(
  // Clock and reset
  input  wire logic                         CLOCK_IN,
  input  wire logic                         NRST_IN,
  // CPU bus
  input  wire logic [15:0]                  ADDR_IN,
  input  wire logic                         RD_IN,
  input  wire logic                         WR_IN,
  // Size register writes
  input  wire logic                         MSS_WR_IN,
  input  wire logic                         XSS_WR_IN,
  input  wire logic [7:0]                   WDATA_IN,
  // Configuration
  input  wire logic                         BOOT_SWAP_IN,
  input  wire logic                         CLUSTER0_PROTECT_IN,
  // Size registers
  output logic [7:0]                        MEMORY_SIZE_SELECT_OUT,
  output logic [7:0]                        EXPANSION_RAM_SIZE_SELECT_OUT,
  // Chip selects and cluster 0 write block flag
  output logic                              ROM_CS_OUT,
  output logic                              HRAM_CS_OUT,
  output logic                              XRAM_CS_OUT,
  output logic                              SFR_CS_OUT,
  output logic                              OPT_CS_OUT,
  output logic                              SID_CS_OUT,
  output logic                              WR_BLOCKED_OUT,
  // Flash block
  output logic [mem_map_pkg::BLOCK_W-1:0]   BLOCK_OUT,
  output logic                              BLOCK_VALID_OUT,
  output logic [mem_map_pkg::BLOCK_W-1:0]   LAST_BLOCK_OUT
);
  import mem_map_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] memory_size_select;
    logic [7:0] expansion_ram_size_select;
  } state_t;

  state_t      st;
  state_t      next_st;
  logic [5:0]  last_blk;
  logic [15:0] rom_last;
  logic [15:0] hram_base;
  logic        xram_on;
  logic        hit_hram;
  logic        hit_xram;
  logic        hit_opt;
  logic        hit_sid;
  logic        hit_opt2;
  logic        hit_sid2;
  logic        access;
  logic [5:0]  blk;

  always_comb
  begin
    next_st = st;
    if (MSS_WR_IN)
    begin
      next_st.memory_size_select = WDATA_IN;                          // [RQ12]
    end
    if (XSS_WR_IN)
    begin
      next_st.expansion_ram_size_select = WDATA_IN;                   // [RQ12]
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      st.memory_size_select        <= MSS_RESET;                      // [RQ2]
      st.expansion_ram_size_select <= XSS_RESET;                      // [RQ2]
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Size decode
  always_comb
  begin
    unique case (st.memory_size_select)                               // [RQ10]
      MSS_16K: last_blk = LAST_BLK_16K;
      MSS_24K: last_blk = LAST_BLK_24K;
      MSS_32K: last_blk = LAST_BLK_32K;
      MSS_48K: last_blk = LAST_BLK_48K;
      default: last_blk = LAST_BLK_60K;
    endcase
  end

  assign rom_last  = {last_blk, 10'h3FF};                             // [RQ8]
  assign hram_base = (st.memory_size_select == MSS_16K) ? HRAM_BASE_768 : HRAM_BASE_1K;
  assign xram_on   = (st.expansion_ram_size_select == XSS_1K);        // [RQ12]

  ////////////////////////////////////////////////////////////////////////////
  // Range compares
  range_hit u_hram (.addr_in(ADDR_IN), .base_in(hram_base), .last_in(HRAM_LAST),
                    .hit_out(hit_hram));
  range_hit u_xram (.addr_in(ADDR_IN), .base_in(XRAM_BASE), .last_in(XRAM_LAST),
                    .hit_out(hit_xram));
  range_hit u_opt  (.addr_in(ADDR_IN), .base_in(OPT_BASE), .last_in(OPT_LAST),
                    .hit_out(hit_opt));
  range_hit u_sid  (.addr_in(ADDR_IN), .base_in(SID_BASE), .last_in(SID_LAST),
                    .hit_out(hit_sid));
  range_hit u_opt2 (.addr_in(ADDR_IN), .base_in(OPT_BASE + SWAP_OFFSET),
                    .last_in(OPT_LAST + SWAP_OFFSET), .hit_out(hit_opt2));
  range_hit u_sid2 (.addr_in(ADDR_IN), .base_in(SID_BASE + SWAP_OFFSET),
                    .last_in(SID_LAST + SWAP_OFFSET), .hit_out(hit_sid2));

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign access = RD_IN | WR_IN;                                      // [RQ1]
  assign blk    = ADDR_IN[15:BLOCK_LSB];                              // [RQ9]

  assign MEMORY_SIZE_SELECT_OUT        = st.memory_size_select;
  assign EXPANSION_RAM_SIZE_SELECT_OUT = st.expansion_ram_size_select;
  assign ROM_CS_OUT      = access && (ADDR_IN <= rom_last)
                           && !(WR_IN && WR_BLOCKED_OUT);             // [RQ12] [RQ7]
  assign HRAM_CS_OUT     = access && hit_hram;                        // [RQ12]
  assign XRAM_CS_OUT     = access && xram_on && hit_xram;             // [RQ12]
  assign SFR_CS_OUT      = access && (ADDR_IN >= SFR_BASE);           // [RQ11]
  assign OPT_CS_OUT      = access && (hit_opt || (BOOT_SWAP_IN && hit_opt2)); // [RQ5]
  assign SID_CS_OUT      = access && (hit_sid || (BOOT_SWAP_IN && hit_sid2)); // [RQ5]
  assign WR_BLOCKED_OUT  = WR_IN && CLUSTER0_PROTECT_IN
                           && (ADDR_IN <= CLUSTER0_LAST);             // [RQ7]
  assign BLOCK_OUT       = blk;                                       // [RQ9]
  assign BLOCK_VALID_OUT = (blk <= last_blk);                         // [RQ10]
  assign LAST_BLOCK_OUT  = last_blk;                                  // [RQ10]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_vals;
    @(posedge CLOCK_IN) !NRST_IN |=> (MEMORY_SIZE_SELECT_OUT == 8'hCF)
      && (EXPANSION_RAM_SIZE_SELECT_OUT == 8'h0C);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset size"); // [RQ2]

  sequence s_mss_req;
    MSS_WR_IN;
  endsequence

  property p_mss_write;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      s_mss_req |=> MEMORY_SIZE_SELECT_OUT == $past(WDATA_IN);
  endproperty
  a_mss_write: assert property (p_mss_write) else $error("size write lost"); // [RQ12]

  sequence s_xss_req;
    XSS_WR_IN;
  endsequence

  property p_xss_write;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      s_xss_req |=> EXPANSION_RAM_SIZE_SELECT_OUT == $past(WDATA_IN);
  endproperty
  a_xss_write: assert property (p_xss_write) else $error("exp size write lost"); // [RQ12]

  property p_block_num;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      BLOCK_OUT == ADDR_IN[15:10];
  endproperty
  a_block_num: assert property (p_block_num) else $error("bad block"); // [RQ9]

  property p_limit_16k;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (MEMORY_SIZE_SELECT_OUT == 8'h04) |-> LAST_BLOCK_OUT == 6'h0F;
  endproperty
  a_limit_16k: assert property (p_limit_16k) else $error("bad 16K limit"); // [RQ10]

  property p_limit_60k;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (MEMORY_SIZE_SELECT_OUT == 8'hCF) |-> LAST_BLOCK_OUT == 6'h3B;
  endproperty
  a_limit_60k: assert property (p_limit_60k) else $error("bad 60K limit"); // [RQ10]

  property p_limit_32k;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (MEMORY_SIZE_SELECT_OUT == 8'hC8) |-> LAST_BLOCK_OUT == 6'h1F;
  endproperty
  a_limit_32k: assert property (p_limit_32k) else $error("bad 32K limit"); // [RQ10]

  property p_sfr;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (RD_IN && ADDR_IN[15:8] == 8'hFF) |-> SFR_CS_OUT && !ROM_CS_OUT;
  endproperty
  a_sfr: assert property (p_sfr) else $error("SFR decode"); // [RQ11]

  property p_opt;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (RD_IN && ADDR_IN == 16'h1080) |-> OPT_CS_OUT == BOOT_SWAP_IN;
  endproperty
  a_opt: assert property (p_opt) else $error("option swap decode"); // [RQ5]

  property p_sid;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (RD_IN && ADDR_IN == 16'h1085) |-> SID_CS_OUT == BOOT_SWAP_IN;
  endproperty
  a_sid: assert property (p_sid) else $error("security id swap decode"); // [RQ5]

  property p_protect;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (WR_IN && CLUSTER0_PROTECT_IN && ADDR_IN < 16'h1000) |-> !ROM_CS_OUT;
  endproperty
  a_protect: assert property (p_protect) else $error("cluster 0 write passed"); // [RQ7]

  property p_xram;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (EXPANSION_RAM_SIZE_SELECT_OUT == 8'h0C) |-> !XRAM_CS_OUT;
  endproperty
  a_xram: assert property (p_xram) else $error("xram without size"); // [RQ12]

  property p_hram_16k;
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
      (MEMORY_SIZE_SELECT_OUT == 8'h04 && RD_IN && ADDR_IN == 16'hFB00) |-> !HRAM_CS_OUT;
  endproperty
  a_hram_16k: assert property (p_hram_16k) else $error("hram below 768 byte base"); // [RQ12]
endmodule

// [rtl/mem_map_pkg.sv]
// Constants for the memory space size decoder
// Assumes a 16-bit CPU address bus and 8-bit size registers
package mem_map_pkg;
  localparam int           ADDR_W          = 16;
  localparam int           BLOCK_W         = 6;
  localparam int           BLOCK_LSB       = 10;
  localparam logic [7:0]   MSS_RESET       = 8'hCF;
  localparam logic [7:0]   XSS_RESET       = 8'h0C;
  localparam logic [7:0]   MSS_16K         = 8'h04;
  localparam logic [7:0]   MSS_24K         = 8'hC6;
  localparam logic [7:0]   MSS_32K         = 8'hC8;
  localparam logic [7:0]   MSS_48K         = 8'hCC;
  localparam logic [7:0]   MSS_60K         = 8'hCF;
  localparam logic [7:0]   XSS_1K          = 8'h0A;
  localparam logic [7:0]   XSS_NONE        = 8'h0C;
  localparam logic [5:0]   LAST_BLK_16K    = 6'h0F;
  localparam logic [5:0]   LAST_BLK_24K    = 6'h17;
  localparam logic [5:0]   LAST_BLK_32K    = 6'h1F;
  localparam logic [5:0]   LAST_BLK_48K    = 6'h2F;
  localparam logic [5:0]   LAST_BLK_60K    = 6'h3B;
  localparam logic [15:0]  HRAM_BASE_768   = 16'hFC00;
  localparam logic [15:0]  HRAM_BASE_1K    = 16'hFB00;
  localparam logic [15:0]  HRAM_LAST       = 16'hFEFF;
  localparam logic [15:0]  XRAM_BASE       = 16'hF400;
  localparam logic [15:0]  XRAM_LAST       = 16'hF7FF;
  localparam logic [15:0]  SFR_BASE        = 16'hFF00;
  localparam logic [15:0]  OPT_BASE        = 16'h0080;
  localparam logic [15:0]  OPT_LAST        = 16'h0084;
  localparam logic [15:0]  SID_BASE        = 16'h0085;
  localparam logic [15:0]  SID_LAST        = 16'h008E;
  localparam logic [15:0]  SWAP_OFFSET     = 16'h1000;
  localparam logic [15:0]  CLUSTER0_LAST   = 16'h0FFF;
endpackage

// [rtl/range_hit.sv]
// Inclusive address range comparator
// Assumes base not above last
`timescale 1ns/1ps
module range_hit
(
  // Compare
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] base_in,
  input  wire logic [15:0] last_in,
  // Result
  output logic             hit_out
);
  assign hit_out = (addr_in >= base_in) && (addr_in <= last_in);
endmodule

// [verification/cpu_bus_model.sv]
// CPU side model: address, access strobes and size register writes
// Assumes the bench calls its tasks; everything changes at the falling edge
`timescale 1ns/1ps
module cpu_bus_model
(
  // Clock
  input  wire logic        clk_in,
  // Bus
  output logic [15:0]      addr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic             mss_wr_out,
  output logic             xss_wr_out,
  output logic [7:0]       wdata_out
);
  initial
  begin
    addr_out = 16'h0000;
    rd_out = 1'b0;
    wr_out = 1'b0;
    mss_wr_out = 1'b0;
    xss_wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One access, held until the next call
  task automatic access(input logic [15:0] a, input logic w);
    @(negedge clk_in);
    addr_out = a;
    rd_out = !w;
    wr_out = w;
  endtask
  // Size register write for one edge, data inverted once released
  task automatic size_write(input logic x, input logic [7:0] d);
    @(negedge clk_in);
    mss_wr_out = !x;
    xss_wr_out = x;
    wdata_out = d;
    @(negedge clk_in);
    mss_wr_out = 1'b0;
    xss_wr_out = 1'b0;
    wdata_out = ~d;
  endtask
endmodule

// [verification/mem_space_decoder_tb_top.sv]
// Bench for the memory space size decoder
// Assumes the CPU bus model drives the bus; checks outputs after settling
`timescale 1ns/1ps
module mem_space_decoder_tb_top;
  import mem_map_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, swap = 1'b0, prot = 1'b0;
  logic [15:0] addr;
  logic rd, wr, mwr, xwr, rom, hram, xram, sfr, opt, sid, blkd, bval;
  logic [7:0] wdata, mss, xss;
  logic [5:0] blk, lastb;
  int fails = 0, cmp_count = 0;
  always #5 clock = ~clock;
  cpu_bus_model cpu_bus_model_i (.clk_in(clock), .addr_out(addr), .rd_out(rd), .wr_out(wr),
    .mss_wr_out(mwr), .xss_wr_out(xwr), .wdata_out(wdata));
  mem_space_decoder mem_space_decoder_i (.CLOCK_IN(clock), .NRST_IN(nrst), .ADDR_IN(addr),
    .RD_IN(rd), .WR_IN(wr), .MSS_WR_IN(mwr), .XSS_WR_IN(xwr), .WDATA_IN(wdata),
    .BOOT_SWAP_IN(swap), .CLUSTER0_PROTECT_IN(prot), .MEMORY_SIZE_SELECT_OUT(mss),
    .EXPANSION_RAM_SIZE_SELECT_OUT(xss), .ROM_CS_OUT(rom), .HRAM_CS_OUT(hram),
    .XRAM_CS_OUT(xram), .SFR_CS_OUT(sfr), .OPT_CS_OUT(opt), .SID_CS_OUT(sid),
    .WR_BLOCKED_OUT(blkd), .BLOCK_OUT(blk), .BLOCK_VALID_OUT(bval), .LAST_BLOCK_OUT(lastb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic at(input logic [15:0] a, input logic w);
    cpu_bus_model_i.access(a, w);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sizes();
    logic [7:0] code [5] = '{MSS_16K, MSS_24K, MSS_32K, MSS_48K, MSS_60K};
    logic [5:0] lim [5] = '{6'h0F, 6'h17, 6'h1F, 6'h2F, 6'h3B};
    for (int i = 0; i < 5; i++)
    begin
      cpu_bus_model_i.size_write(1'b0, code[i]);
      at({lim[i], 10'h3FF}, 1'b0);
      chk(mss, code[i], "size reg");
      chk(lastb, lim[i], "last block");
      chk({rom, bval}, 2'b11, "rom top");
      at({lim[i] + 6'h01, 10'h000}, 1'b0);
      chk({rom, bval}, 2'b00, "rom beyond");
      at(16'hFB00, 1'b0);
      chk(hram, i != 0, "hram low edge");
    end
  endtask
  task automatic t_blocks();
    for (int k = 0; k < 64; k++)
    begin
      at({k[5:0], k[9:0] * 10'd37}, 1'b0);
      chk(blk, k[5:0], "block number");
      chk({rom, bval}, {2{k <= LAST_BLK_60K}}, "block in range");
    end
  endtask
  task automatic t_regions();
    logic [15:0] a [6] = '{16'h0080, 16'h0084, 16'h0085, 16'h008E, 16'h008F, 16'h007F};
    logic [1:0] e [6] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b00, 2'b00};
    for (int s = 0; s < 2; s++)
    begin
      @(negedge clock);
      swap = s[0];
      for (int i = 0; i < 6; i++)
      begin
        at(a[i], 1'b0);
        chk({opt, sid}, e[i], "low region");
        at(a[i] | SWAP_OFFSET, 1'b0);
        chk({opt, sid}, s[0] ? e[i] : 2'b00, "swap copy");
      end
    end
  endtask
  task automatic t_protect();
    @(negedge clock);
    prot = 1'b1;
    at(16'h0100, 1'b1);
    chk({rom, blkd}, 2'b01, "protected write");
    at(16'h1000, 1'b1);
    chk({rom, blkd}, 2'b10, "outside cluster");
    @(negedge clock);
    prot = 1'b0;
    at(16'h0FFF, 1'b1);
    chk({rom, blkd}, 2'b10, "unprotected write");
  endtask
  task automatic t_xram_sfr();
    at(16'hF400, 1'b0);
    chk(xram, 1'b0, "xram absent");
    cpu_bus_model_i.size_write(1'b1, XSS_1K);
    chk(xss, XSS_1K, "exp size reg");
    at(16'hF7FF, 1'b1);
    chk(xram, 1'b1, "xram top");
    at(16'hF800, 1'b0);
    chk(xram, 1'b0, "xram beyond");
    at(16'hFF00, 1'b0);
    chk({sfr, hram}, 2'b10, "sfr base");
    at(16'hFFFF, 1'b1);
    chk(sfr, 1'b1, "sfr top");
    at(16'hFEFF, 1'b0);
    chk({sfr, hram}, 2'b01, "below sfr");
  endtask
  task automatic t_rereset();
    cpu_bus_model_i.size_write(1'b0, MSS_16K);
    chk(mss, MSS_16K, "size before reset");
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    #1;
    chk({mss, xss}, 16'hCF0C, "sizes after second reset");
    chk(lastb, 6'h3B, "limit after second reset");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    #1;
    chk({mss, xss}, 16'hCF0C, "reset sizes");
    chk(lastb, 6'h3B, "reset limit");
    t_blocks();
    t_regions();
    t_protect();
    t_xram_sfr();
    t_sizes();
    t_rereset();
    wrap_up();
  end
endmodule
